/* design/oau_core.sv */
// Operand addressing unit: decode, extension fetch, address, byte writes
//
// Contract
// - Decode source and destination mode fields
// - Register and indexed modes for either operand; source 10 and 11 decode as register
// - Register operand accessed as word or byte
// - Byte register write clears upper byte
// - Byte flags come from eight-bit result
// - Indexed address is base plus signed index
// - Indexed base registers stay unchanged
// - One opcode plus one word per extended operand
// - Program counter skips every extension word
// - Symbolic address is counter plus offset
// - Absolute address is extension word alone
// - Absolute is indexed with zero flags base
// - Symbolic base is extension word address
`timescale 1ns/100ps
module oau_core
    import oau_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // Instruction from decode
    input  wire logic        instr_valid_in,
    input  wire logic [1:0]  source_mode_field_in,
    input  wire logic        dst_mode_in,
    input  wire logic [3:0]  src_reg_in,
    input  wire logic [3:0]  dst_reg_in,
    input  wire logic        byte_op_in,
    input  wire logic [15:0] src_base_val_in,
    input  wire logic [15:0] dst_base_val_in,
    output logic             instr_ready_out,
    // Memory bus for extension words
    output logic             mem_rd_out,
    output logic      [15:0] mem_addr_out,
    input  wire logic        mem_ack_in,
    input  wire logic [15:0] mem_data_in,
    // Operand addresses to execute
    output logic             ops_valid_out,
    output logic      [15:0] src_addr_out,
    output logic      [15:0] dst_addr_out,
    output logic             src_is_reg_out,
    output logic             dst_is_reg_out,
    output logic      [15:0] pc_out,
    // Execute result write-back
    input  wire logic        res_valid_in,
    input  wire logic [15:0] res_in,
    input  wire logic        res_c_in,
    input  wire logic        res_v_in,
    output logic             wr_en_out,
    output logic      [3:0]  wr_reg_out,
    output logic      [15:0] wr_data_out,
    output logic      [3:0]  flags_out
);
    // ========================================================
    // Decode
    // ========================================================
    oau_state_t  state_reg;
    logic [15:0] pc_reg;
    logic        src_ext_reg;
    logic        dst_ext_reg;
    logic [3:0]  src_sel_reg;
    logic [3:0]  dst_sel_reg;
    logic [15:0] src_bval_reg;
    logic [15:0] dst_bval_reg;
    logic        byte_reg;
    logic [15:0] src_addr_reg;
    logic [15:0] dst_addr_reg;
    logic [15:0] eff_addr;
    logic        src_ext;
    logic        dst_ext;
    logic [15:0] res_w;

    // Only the 01/1 encodings need an extension word
    assign src_ext = (source_mode_field_in == SRC_MODE_IDX);
    assign dst_ext = (dst_mode_in == DST_MODE_IDX);

    assign instr_ready_out = (state_reg == ST_IDLE);
    assign mem_rd_out      = (state_reg == ST_SRC) || (state_reg == ST_DST);
    // Extension words sit right after the opcode at the counter
    assign mem_addr_out    = pc_reg;
    assign ops_valid_out   = (state_reg == ST_EXEC);
    assign src_addr_out    = src_addr_reg;
    assign dst_addr_out    = dst_addr_reg;
    assign src_is_reg_out  = !src_ext_reg;
    assign dst_is_reg_out  = !dst_ext_reg;
    assign pc_out          = pc_reg;

    // ========================================================
    // Address generation
    // ========================================================
    oau_addr_calc u_calc
    (
        .base_sel_in  (state_reg == ST_SRC ? src_sel_reg : dst_sel_reg),
        .base_val_in  (state_reg == ST_SRC ? src_bval_reg : dst_bval_reg),
        .ext_addr_in  (pc_reg),
        .ext_word_in  (mem_data_in),
        .eff_addr_out (eff_addr)
    );

    // ========================================================
    // Sequencer
    // ========================================================
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    if (instr_valid_in)
                    begin
                        // Source word first when both present
                        if (src_ext)
                            state_reg <= ST_SRC;
                        else if (dst_ext)
                            state_reg <= ST_DST;
                        else
                            state_reg <= ST_EXEC;
                    end
                ST_SRC:
                    if (mem_ack_in)
                        state_reg <= dst_ext_reg ? ST_DST : ST_EXEC;
                ST_DST:
                    if (mem_ack_in)
                        state_reg <= ST_EXEC;
                ST_EXEC:
                    if (res_valid_in)
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Captured operand descriptors; base values are copied, never written
    // back, so base registers stay as they were
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            src_ext_reg  <= 1'b0;
            dst_ext_reg  <= 1'b0;
            src_sel_reg  <= 4'h0;
            dst_sel_reg  <= 4'h0;
            src_bval_reg <= WORD_RESET;
            dst_bval_reg <= WORD_RESET;
            byte_reg     <= 1'b0;
        end
        else if (state_reg == ST_IDLE && instr_valid_in)
        begin
            src_ext_reg  <= src_ext;
            dst_ext_reg  <= dst_ext;
            src_sel_reg  <= src_reg_in;
            dst_sel_reg  <= dst_reg_in;
            src_bval_reg <= src_base_val_in;
            dst_bval_reg <= dst_base_val_in;
            byte_reg     <= byte_op_in;
        end
    end

    // Program counter: opcode word on accept, one step per extension
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            pc_reg <= PC_RESET;
        else if (state_reg == ST_IDLE && instr_valid_in)
            pc_reg <= pc_reg + PC_STEP;
        else if (mem_rd_out && mem_ack_in)
            pc_reg <= pc_reg + PC_STEP;
    end

    // Effective addresses
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            src_addr_reg <= WORD_RESET;
            dst_addr_reg <= WORD_RESET;
        end
        else
        begin
            if (state_reg == ST_SRC && mem_ack_in)
                src_addr_reg <= eff_addr;
            if (state_reg == ST_DST && mem_ack_in)
                dst_addr_reg <= eff_addr;
        end
    end

    // ========================================================
    // Write-back and flags
    // ========================================================
    // Byte result keeps only the low byte, upper byte zero
    assign res_w = byte_reg ? (res_in & BYTE_MASK) : res_in;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_en_out   <= 1'b0;
            wr_reg_out  <= 4'h0;
            wr_data_out <= WORD_RESET;
            flags_out   <= 4'h0;
        end
        else
        begin
            wr_en_out <= ops_valid_out && res_valid_in && !dst_ext_reg;
            if (ops_valid_out && res_valid_in)
            begin
                wr_reg_out  <= dst_sel_reg;
                wr_data_out <= res_w;
                flags_out[FLAG_C] <= res_c_in;
                flags_out[FLAG_V] <= res_v_in;
                // Sign and zero from byte width on byte ops
                flags_out[FLAG_N] <= byte_reg ? res_in[7] : res_in[15];
                flags_out[FLAG_Z] <= (res_w == WORD_RESET);
            end
        end
    end

    // ========================================================
    // Assertions
    // ========================================================
    a_byte_upper_zero: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (ops_valid_out && res_valid_in && byte_reg) |=>
            wr_data_out[15:8] == 8'h00)
        else $error("byte write kept upper byte");

    a_byte_neg_flag: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (ops_valid_out && res_valid_in && byte_reg) |=>
            flags_out[FLAG_N] == $past(res_in[7]))
        else $error("byte sign flag not from bit 7");

    a_reg_only_pc: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (instr_ready_out && instr_valid_in && !src_ext && !dst_ext) |=>
            (pc_reg == $past(pc_reg) + PC_STEP) && ops_valid_out)
        else $error("register-only step wrong");

    a_ext_pc_step: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (mem_rd_out && mem_ack_in) |=> pc_reg == $past(pc_reg) + PC_STEP)
        else $error("counter did not skip extension");

    a_src_first: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (instr_ready_out && instr_valid_in && src_ext && dst_ext) |=>
            state_reg == ST_SRC)
        else $error("destination fetched first");

    a_abs_addr: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (state_reg == ST_SRC && mem_ack_in && src_sel_reg == REG_FLAGS) |=>
            src_addr_reg == $past(mem_data_in))
        else $error("absolute address not extension word");

    a_sym_addr: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (state_reg == ST_DST && mem_ack_in && dst_sel_reg == REG_PC) |=>
            dst_addr_reg == $past(pc_reg) + $past(mem_data_in))
        else $error("symbolic address wrong");

    a_idx_addr: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (state_reg == ST_SRC && mem_ack_in && src_sel_reg != REG_PC &&
         src_sel_reg != REG_FLAGS) |=>
            src_addr_reg == $past(src_bval_reg) + $past(mem_data_in))
        else $error("indexed address wrong");

    a_no_ext_write: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (ops_valid_out && res_valid_in && dst_ext_reg) |=> !wr_en_out)
        else $error("register written on memory destination");

    c_two_ext: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        state_reg == ST_SRC ##[1:20] state_reg == ST_DST);
    c_byte_wr: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        wr_en_out && byte_reg);
    c_abs: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        state_reg == ST_DST && dst_sel_reg == REG_FLAGS && mem_ack_in);
endmodule

/* design/oau_pkg.sv */
// Constants and types for the operand addressing unit
package oau_pkg;
    // Mode field encodings
    localparam logic [1:0] SRC_MODE_REG = 2'h0;
    localparam logic [1:0] SRC_MODE_IDX = 2'h1;
    localparam logic       DST_MODE_REG = 1'h0;
    localparam logic       DST_MODE_IDX = 1'h1;
    // Special base registers
    localparam logic [3:0] REG_PC    = 4'h0;
    localparam logic [3:0] REG_FLAGS = 4'h2;
    // Program counter step per word, and reset values
    localparam logic [15:0] PC_STEP      = 16'h0002;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    localparam logic [15:0] BYTE_MASK    = 16'h00FF;
    // Flag positions in the four-bit flag output
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_SRC  = 3'b001,
        ST_DST  = 3'b010,
        ST_EXEC = 3'b011
    } oau_state_t;
endpackage

/* design/oau_addr_calc.sv */
// Effective address adder for indexed, symbolic and absolute forms
`timescale 1ns/100ps
module oau_addr_calc
    import oau_pkg::*;
(
    // Base selection
    input  wire logic [3:0]  base_sel_in,
    input  wire logic [15:0] base_val_in,
    input  wire logic [15:0] ext_addr_in,
    // Extension word
    input  wire logic [15:0] ext_word_in,
    // Result
    output logic      [15:0] eff_addr_out
);
    logic [15:0] base;

    always_comb
    begin
        // Symbolic base is the address of the extension word itself
        if (base_sel_in == REG_PC)
            base = ext_addr_in;
        // Flags register as base adds zero, giving absolute
        else if (base_sel_in == REG_FLAGS)
            base = WORD_RESET;
        else
            base = base_val_in;
    end

    // Index word is signed; 16-bit wrap gives two's-complement add
    assign eff_addr_out = base + ext_word_in;
endmodule

/* bench/oau_mem_model.sv */
// Memory model that answers extension word reads from the unit
`timescale 1ns/100ps
module oau_mem_model
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // Read request from the unit
    input  wire logic        mem_rd_in,
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [1:0]  delay_in,
    // Answer
    output logic             mem_ack_out,
    output logic      [15:0] mem_data_out
);
    logic [1:0] wait_reg;

    // Contents follow from the address so no preload is needed
    function automatic logic [15:0] mem_word(input logic [15:0] addr);
        return {addr[7:0], ~addr[15:8]} ^ 16'h5a3c;
    endfunction

    // Data is only good in the ack cycle; otherwise it toggles
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mem_ack_out  <= 1'b0;
            mem_data_out <= 16'h0000;
            wait_reg     <= 2'h0;
        end
        else if (mem_ack_out)
        begin
            mem_ack_out  <= 1'b0;
            mem_data_out <= ~mem_data_out;
        end
        else if (mem_rd_in && wait_reg >= delay_in)
        begin
            mem_ack_out  <= 1'b1;
            mem_data_out <= mem_word(mem_addr_in);
            wait_reg     <= 2'h0;
        end
        else
        begin
            mem_data_out <= ~mem_data_out;
            wait_reg     <= mem_rd_in ? wait_reg + 2'h1 : 2'h0;
        end
    end
endmodule

/* bench/cpu_operand_addressing_unit_test.sv */
// Self-checking bench for the operand addressing unit
`timescale 1ns/100ps
module cpu_operand_addressing_unit_test import oau_pkg::*;;
    typedef struct packed
    {
        logic [15:0] sa, da, pc;
        logic        sr, dr;
    } oau_exp_t;
    typedef struct packed
    {
        logic [3:0]  wreg;
        logic [15:0] data;
        logic [3:0]  flags;
    } oau_wb_t;

    logic        clk_sys_in, rst_in, instr_valid_in, dst_mode_in, byte_op_in;
    logic [1:0]  source_mode_field_in, delay_in;
    logic [3:0]  src_reg_in, dst_reg_in, wr_reg_out, flags_out;
    logic [15:0] src_base_val_in, dst_base_val_in, mem_addr_out, mem_data_in;
    logic [15:0] src_addr_out, dst_addr_out, pc_out, res_in, wr_data_out;
    logic        instr_ready_out, mem_rd_out, mem_ack_in, ops_valid_out;
    logic        src_is_reg_out, dst_is_reg_out, wr_en_out, ops_prev;
    logic        res_valid_in, res_c_in, res_v_in;
    logic [15:0] pc_track, addr_q[$];
    oau_exp_t    exp_q[$], e_m;
    oau_wb_t     wr_q[$], w_m;
    integer      seed, n_mismatch, samples_checked;

    oau_core dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out),
        .source_mode_field_in(source_mode_field_in),
        .dst_mode_in(dst_mode_in), .src_reg_in(src_reg_in),
        .dst_reg_in(dst_reg_in), .byte_op_in(byte_op_in),
        .src_base_val_in(src_base_val_in), .dst_base_val_in(dst_base_val_in),
        .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
        .mem_ack_in(mem_ack_in), .mem_data_in(mem_data_in),
        .ops_valid_out(ops_valid_out), .src_addr_out(src_addr_out),
        .dst_addr_out(dst_addr_out), .src_is_reg_out(src_is_reg_out),
        .dst_is_reg_out(dst_is_reg_out), .pc_out(pc_out),
        .res_valid_in(res_valid_in), .res_in(res_in), .res_c_in(res_c_in),
        .res_v_in(res_v_in), .wr_en_out(wr_en_out), .wr_reg_out(wr_reg_out),
        .wr_data_out(wr_data_out), .flags_out(flags_out));

    oau_mem_model m_mem (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .mem_rd_in(mem_rd_out), .mem_addr_in(mem_addr_out),
        .delay_in(delay_in), .mem_ack_out(mem_ack_in),
        .mem_data_out(mem_data_in));

    initial
    begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Polls on falling edges so combinational outputs have settled
    task automatic wait_hi(ref logic s);
        for (int k = 0; k < 64 && s !== 1'b1; k++)
            @(negedge clk_sys_in);
        if (s !== 1'b1)
        begin
            n_mismatch++;
            test_done();
        end
    endtask

    function automatic logic [3:0] reg_of(input logic [1:0] p);
        if (p > 2'h1)
            return 4'h4 | 4'($random(seed));
        return (p == 2'h0) ? REG_PC : REG_FLAGS;
    endfunction

    function automatic logic [15:0] ea_of(input logic [3:0] r,
                                          input logic [15:0] b,
                                          input logic [15:0] ea);
        logic [15:0] w;
        w = m_mem.mem_word(ea);
        return (r == REG_PC) ? ea + w : (r == REG_FLAGS) ? w : b + w;
    endfunction

    // ==========================================================
    // Driver: first sixteen cover every mode pairing with four base pairings, PC or flags base on one side only
    task automatic run_one(input int i);
        logic [1:0]  pick;
        logic [15:0] ea;
        oau_exp_t    e;
        oau_wb_t     w;
        wait_hi(instr_ready_out);
        pick = (i < 16) ? 2'(i >> 2) : 2'($random(seed));
        source_mode_field_in = (i < 16) ? 2'(i & 1) : 2'($random(seed) & 1);
        dst_mode_in = (i < 16) ? i[1] : 1'($random(seed));
        src_reg_in = reg_of(pick);
        dst_reg_in = reg_of(~pick);
        byte_op_in = 1'($random(seed));
        src_base_val_in = 16'($random(seed));
        dst_base_val_in = 16'($random(seed));
        delay_in = 2'($random(seed));
        ea = pc_track + PC_STEP;
        e = '0;
        e.sr = (source_mode_field_in == SRC_MODE_REG);
        e.dr = (dst_mode_in == DST_MODE_REG);
        if (!e.sr)
        begin
            addr_q.push_back(ea);
            e.sa = ea_of(src_reg_in, src_base_val_in, ea);
            ea += PC_STEP;
        end
        if (!e.dr)
        begin
            addr_q.push_back(ea);
            e.da = ea_of(dst_reg_in, dst_base_val_in, ea);
            ea += PC_STEP;
        end
        e.pc = ea;
        pc_track = ea;
        exp_q.push_back(e);
        instr_valid_in = 1'b1;
        @(negedge clk_sys_in);
        instr_valid_in = 1'b0;
        wait_hi(ops_valid_out);
        repeat ($random(seed) & 3) @(negedge clk_sys_in);
        res_in = 16'($random(seed)) & ((i % 5 == 0) ? 16'hff00 : 16'hffff);
        {res_c_in, res_v_in} = 2'($random(seed));
        w.wreg = dst_reg_in;
        w.data = byte_op_in ? (res_in & BYTE_MASK) : res_in;
        w.flags = {res_v_in, byte_op_in ? res_in[7] : res_in[15],
                   w.data == 16'h0000, res_c_in};
        if (e.dr)
            wr_q.push_back(w);
        res_valid_in = 1'b1;
        @(negedge clk_sys_in);
        res_valid_in = 1'b0;
    endtask

    // ==========================================================
    // Monitor: each result takes the oldest note of its kind
    always @(negedge clk_sys_in)
    begin
        if (mem_ack_in === 1'b1 && mem_rd_out === 1'b1)
            check(mem_addr_out, addr_q.pop_front());
        if (ops_valid_out === 1'b1 && ops_prev !== 1'b1)
        begin
            e_m = exp_q.pop_front();
            check(16'(src_is_reg_out), 16'(e_m.sr));
            check(16'(dst_is_reg_out), 16'(e_m.dr));
            if (!e_m.sr)
                check(src_addr_out, e_m.sa);
            if (!e_m.dr)
                check(dst_addr_out, e_m.da);
            check(pc_out, e_m.pc);
        end
        if (wr_en_out === 1'b1)
        begin
            check(16'(wr_q.size() != 0), 16'h0001);
            w_m = wr_q.pop_front();
            check(16'(wr_reg_out), 16'(w_m.wreg));
            check(wr_data_out, w_m.data);
            check(16'(flags_out), 16'(w_m.flags));
        end
        ops_prev = ops_valid_out;
    end

    initial
    begin
        seed = 32'h1696_a6f3;
        {n_mismatch, samples_checked, pc_track} = '0;
        {instr_valid_in, dst_mode_in, byte_op_in, res_valid_in} = 4'h0;
        {res_c_in, res_v_in, source_mode_field_in, delay_in} = 6'h00;
        {src_reg_in, dst_reg_in, res_in} = 24'h00_0000;
        {src_base_val_in, dst_base_val_in} = 32'h0000_0000;
        for (int r = 0; r < 2; r++)
        begin
            rst_in = 1'b1;
            pc_track = PC_RESET;
            repeat (4) @(negedge clk_sys_in);
            rst_in = 1'b0;
            check(pc_out, PC_RESET);
            for (int i = 0; i < 40; i++)
                run_one(i);
            repeat (8) @(negedge clk_sys_in);
            check(16'(exp_q.size() + wr_q.size() + addr_q.size()),
                  16'h0000);
        end
        test_done();
    end
endmodule
